// ### design/adc_fmt_consts.svh
// register offsets, field positions, reset values and counts of the output formatter
// assumes: included by bare name from the formatter module
`ifndef ADC_FMT_CONSTS_SVH
`define ADC_FMT_CONSTS_SVH

`define OFS_MODE            8'h01
`define OFS_PAT_UPPER       8'h3c
`define OFS_PAT_MIDDLE      8'h3d
`define OFS_PAT_LOWER       8'h3e
`define OFS_BURST_CTRL      8'h40
`define OFS_BURST_LOG       8'h41
`define OFS_OVR_THRESH      8'h42

`define BIT_HP1             1
`define BIT_AUTOCORR        15
`define BIT_PAT_CUSTOM      15
`define PAT_FIELD_MSB       13
`define PAT_FIELD_LSB       2
`define BIT_BURST_EN        0
`define BIT_BURST_AUTO      1
`define BIT_BURST_DECIM     2

`define MODE_RST            16'h0002
`define PAT_RST             16'h0000
`define OVR_THRESH_RST      4'hf
`define BURST_LOG_RST       5'h0a
`define BURST_LOG_MIN       5'h0a
`define BURST_LOG_MAX       5'h19
`define INIT_LOWRES_LOG     5'h0d
`define LOWRES_EXTRA_LOG    5'h03

`define OVR_LATENCY         12
`define OVR_SCALE_SHIFT     7
`define SYNC_CNT_LAST       5'h1f
`define SYNC_INVALID_SAMPLES 6'h24
`define MASK_LOWRES_FULL    12'hfe0
`define MASK_LOWRES_DECIM   12'hffe
`define DECIM_PHASE_FIRST   2'h0

`endif

// ### design/adc_fmt_pkg.sv
// types shared by the output formatter and its bench
// assumes: constants come from adc_fmt_consts.svh
package adc_fmt_pkg;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] data;
    } reg_write_type;

    typedef enum logic [3:0] {
        BURST_OFF   = 4'b0001,
        BURST_LOCK  = 4'b0010,
        BURST_READY = 4'b0100,
        BURST_HIGH  = 4'b1000
    } burst_state_type;

endpackage

// ### design/adc_output_formatter_sync.sv
// output formatting, burst mode and sync marker logic of a single-channel adc
// assumes: sys_clk is the sample clock; the register write port runs on link_clk;
// trigger and sync pins are asynchronous to sys_clk
//
// Behaviour
// - pattern valid only with hp1 cleared, upper bit 15 set
// - pattern still gets burst formatting and lsb zeroing
// - all-zeros and all-ones codes in three words
// - alternating codes via upper and middle words
// - custom pattern: upper bit 15 set, data field
// - hp1 set and zero words restore conversion data
// - over-range flag 12 cycles after the sample
// - threshold is full scale times field over 16
// - auto-correction enable bit, cleared after reset
// - high-res burst lasts 2^N samples, N 10..25
// - burst end: flag low, lockout 2^(N+3) samples
// - triggers ignored during lockout
// - full-rate low-res keeps 7 msbs
// - decimated low-res keeps 11 msbs, held four
// - decimated output keeps high-res latency
// - first sync resets logic, starts 32-cycle marker
// - sync sampled on sample clock rising edge
// - output invalid 36 samples after sync
// - marker restarts when sync lands elsewhere
// - falling-edge sync stretches output clock half cycle
// - burst enable first sends 2^13 locked samples
// - ready flag at lockout end; rising trigger starts
// - high-res flag covers all 2^N samples
// - auto mode: no trigger, ready pulses once
`timescale 1ns/10ps
`include "adc_fmt_consts.svh"
`default_nettype none

module adc_output_formatter_sync
    import adc_fmt_pkg::*;
#(
    parameter int DATA_W = 12,
    parameter int CNT_W  = 29
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              link_clk,
    input  wire logic              link_rst,
    input  wire logic              reg_wr_en,
    input  wire reg_write_type     reg_wr,
    output logic                   reg_busy,
    input  wire logic [DATA_W-1:0] adc_sample,
    input  wire logic              burst_trigger_input,
    input  wire logic              sync_input,
    output logic [DATA_W-1:0]      output_data_bus,
    output logic                   output_data_clock,
    output logic                   high_resolution_flag,
    output logic                   trigger_ready_flag,
    output logic                   sync_marker_output,
    output logic                   fast_overrange_flag,
    output logic                   output_valid,
    output logic                   autocorr_enable
);

    // link domain: one write in flight, held stable until the sample side acknowledges
    reg_write_type hold_q;
    logic          req_tgl_q;
    logic          busy_q;
    logic          ack_s1_q;
    logic          ack_s2_q;
    logic          ack_s3_q;
    logic          ack_lvl_q;
    logic          ack_tgl_q;

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            ack_s1_q  <= 1'b0;
            ack_s2_q  <= 1'b0;
            ack_s3_q  <= 1'b0;
            ack_lvl_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
            if (ack_s2_q == ack_s3_q) begin
                ack_lvl_q <= ack_s3_q;
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            hold_q    <= '0;
            req_tgl_q <= 1'b0;
            busy_q    <= 1'b0;
        end else if (reg_wr_en && !busy_q) begin
            hold_q    <= reg_wr;
            req_tgl_q <= ~req_tgl_q;
            busy_q    <= 1'b1;
        end else if (busy_q && (ack_lvl_q == req_tgl_q)) begin
            busy_q <= 1'b0;
        end
    end

    assign reg_busy = busy_q;

    // sample domain: request toggle crossing
    logic req_s1_q;
    logic req_s2_q;
    logic req_s3_q;
    logic req_seen_q;
    logic wr_take;

    assign wr_take = (req_s2_q == req_s3_q) && (req_s3_q != req_seen_q);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            req_s1_q   <= 1'b0;
            req_s2_q   <= 1'b0;
            req_s3_q   <= 1'b0;
            req_seen_q <= 1'b0;
            ack_tgl_q  <= 1'b0;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            if (wr_take) begin
                req_seen_q <= req_s3_q;
                ack_tgl_q  <= req_s3_q;
            end
        end
    end

    // register file
    logic [15:0] mode_q;
    logic [15:0] pat_upper_q;
    logic [15:0] pat_middle_q;
    logic [15:0] pat_lower_q;
    logic [2:0]  burst_ctrl_q;
    logic [4:0]  burst_log_q;
    logic [3:0]  ovr_thresh_q;
    logic [4:0]  log_wr;

    // out-of-range N is pinned to the legal limits rather than refused
    assign log_wr = (hold_q.data[4:0] < `BURST_LOG_MIN) ? `BURST_LOG_MIN :
                    (hold_q.data[4:0] > `BURST_LOG_MAX) ? `BURST_LOG_MAX :
                    hold_q.data[4:0];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode_q       <= `MODE_RST;
            pat_upper_q  <= `PAT_RST;
            pat_middle_q <= `PAT_RST;
            pat_lower_q  <= `PAT_RST;
            burst_ctrl_q <= '0;
            burst_log_q  <= `BURST_LOG_RST;
            ovr_thresh_q <= `OVR_THRESH_RST;
        end else if (wr_take) begin
            case (hold_q.addr)
                `OFS_MODE:       mode_q       <= hold_q.data;
                `OFS_PAT_UPPER:  pat_upper_q  <= hold_q.data;
                `OFS_PAT_MIDDLE: pat_middle_q <= hold_q.data;
                `OFS_PAT_LOWER:  pat_lower_q  <= hold_q.data;
                `OFS_BURST_CTRL: burst_ctrl_q <= hold_q.data[2:0];
                `OFS_BURST_LOG:  burst_log_q  <= log_wr;
                `OFS_OVR_THRESH: ovr_thresh_q <= hold_q.data[3:0];
                default:         mode_q       <= mode_q;
            endcase
        end
    end

    logic burst_en;
    logic burst_auto;
    logic burst_decim;

    assign burst_en    = burst_ctrl_q[`BIT_BURST_EN];
    assign burst_auto  = burst_ctrl_q[`BIT_BURST_AUTO];
    assign burst_decim = burst_ctrl_q[`BIT_BURST_DECIM];

    // pin inputs: three flops, a level counts once stages two and three agree
    logic trg_s1_q;
    logic trg_s2_q;
    logic trg_s3_q;
    logic trg_lvl_q;
    logic syn_s1_q;
    logic syn_s2_q;
    logic syn_s3_q;
    logic syn_lvl_q;
    logic trig_rise;
    logic sync_rise;

    assign trig_rise = (trg_s2_q == trg_s3_q) && trg_s3_q && !trg_lvl_q;
    assign sync_rise = (syn_s2_q == syn_s3_q) && syn_s3_q && !syn_lvl_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trg_s1_q  <= 1'b0;
            trg_s2_q  <= 1'b0;
            trg_s3_q  <= 1'b0;
            trg_lvl_q <= 1'b0;
            syn_s1_q  <= 1'b0;
            syn_s2_q  <= 1'b0;
            syn_s3_q  <= 1'b0;
            syn_lvl_q <= 1'b0;
        end else begin
            trg_s1_q <= burst_trigger_input;
            trg_s2_q <= trg_s1_q;
            trg_s3_q <= trg_s2_q;
            syn_s1_q <= sync_input;
            syn_s2_q <= syn_s1_q;
            syn_s3_q <= syn_s2_q;
            if (trg_s2_q == trg_s3_q) begin
                trg_lvl_q <= trg_s3_q;
            end
            if (syn_s2_q == syn_s3_q) begin
                syn_lvl_q <= syn_s3_q;
            end
        end
    end

    // sync: a periodic sync landing where the counter wraps anyway changes nothing
    logic       sync_run_q;
    logic [4:0] sync_cnt_q;
    logic       sync_restart;
    logic [5:0] invalid_q;
    logic       marker_q;
    logic       valid_q;

    assign sync_restart = sync_rise && !(sync_run_q && (sync_cnt_q == `SYNC_CNT_LAST));

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync_run_q <= 1'b0;
            sync_cnt_q <= '0;
            marker_q   <= 1'b0;
        end else if (sync_restart) begin
            sync_run_q <= 1'b1;
            sync_cnt_q <= '0;
            marker_q   <= 1'b1;
        end else begin
            if (sync_run_q) begin
                sync_cnt_q <= sync_cnt_q + 5'h01;
            end
            marker_q <= sync_run_q && (sync_cnt_q == `SYNC_CNT_LAST);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            invalid_q <= '0;
            valid_q   <= 1'b0;
        end else if (sync_restart) begin
            invalid_q <= `SYNC_INVALID_SAMPLES;
            valid_q   <= 1'b0;
        end else begin
            if (invalid_q != '0) begin
                invalid_q <= invalid_q - 6'h01;
            end
            valid_q <= (invalid_q <= 6'h01);
        end
    end

    // forwarded ddr clock: one sample per edge
    logic dclk_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dclk_q <= 1'b0;
        end else if (sync_restart && dclk_q) begin
            dclk_q <= dclk_q;
        end else begin
            dclk_q <= ~dclk_q;
        end
    end

    // burst sequencer
    burst_state_type state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [4:0]       log_act_q;
    logic             auto_pulse_q;
    logic [4:0]       log_lock;

    function automatic logic [CNT_W-1:0] span(input logic [4:0] lg);
        span = (CNT_W'(1) << lg) - CNT_W'(1);
    endfunction

    assign log_lock = burst_log_q + `LOWRES_EXTRA_LOG;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q      <= BURST_OFF;
            cnt_q        <= '0;
            log_act_q    <= `BURST_LOG_RST;
            auto_pulse_q <= 1'b0;
        end else if (!burst_en) begin
            state_q      <= BURST_OFF;
            auto_pulse_q <= 1'b0;
        end else if (sync_restart) begin
            // logic reset by sync restarts the initial lockout
            state_q      <= BURST_LOCK;
            cnt_q        <= span(`INIT_LOWRES_LOG);
            auto_pulse_q <= 1'b0;
        end else begin
            auto_pulse_q <= 1'b0;
            case (state_q)
                BURST_OFF: begin
                    state_q <= BURST_LOCK;
                    cnt_q   <= span(`INIT_LOWRES_LOG);
                end
                BURST_LOCK: begin
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - CNT_W'(1);
                    end else if (burst_auto) begin
                        state_q      <= BURST_HIGH;
                        cnt_q        <= span(log_act_q);
                        auto_pulse_q <= 1'b1;
                    end else begin
                        state_q <= BURST_READY;
                    end
                end
                BURST_READY: begin
                    if (burst_auto) begin
                        state_q      <= BURST_HIGH;
                        cnt_q        <= span(log_act_q);
                        auto_pulse_q <= 1'b1;
                    end else if (trig_rise) begin
                        state_q <= BURST_HIGH;
                        cnt_q   <= span(log_act_q);
                    end
                end
                BURST_HIGH: begin
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - CNT_W'(1);
                    end else begin
                        // N is sampled again only here, at the start of a low-res stretch
                        state_q   <= BURST_LOCK;
                        log_act_q <= burst_log_q;
                        cnt_q     <= span(log_lock);
                    end
                end
                default: state_q <= BURST_OFF;
            endcase
        end
    end

    // data source: test pattern alternates upper and middle fields
    logic              pat_phase_q;
    logic              pattern_on;
    logic [DATA_W-1:0] pat_word;
    logic [DATA_W-1:0] src;

    // lower word is stored for completeness; generation uses upper and middle
    assign pattern_on = !mode_q[`BIT_HP1] && pat_upper_q[`BIT_PAT_CUSTOM];
    assign pat_word   = pat_phase_q ? pat_middle_q[`PAT_FIELD_MSB:`PAT_FIELD_LSB] :
                                      pat_upper_q[`PAT_FIELD_MSB:`PAT_FIELD_LSB];
    assign src        = pattern_on ? pat_word : adc_sample;

    always_ff @(posedge sys_clk) begin
        if (rst || sync_restart) begin
            pat_phase_q <= 1'b0;
        end else begin
            pat_phase_q <= ~pat_phase_q;
        end
    end

    // low-res formatting; the decimated path adds no stage so latency matches high-res
    logic [1:0]        dec_phase_q;
    logic [DATA_W-1:0] dec_hold_q;
    logic [DATA_W-1:0] dec_word;
    logic [DATA_W-1:0] fmt_word;
    logic              low_res;

    assign low_res  = (state_q == BURST_LOCK) || (state_q == BURST_READY);
    assign dec_word = (dec_phase_q == `DECIM_PHASE_FIRST) ? (src & `MASK_LOWRES_DECIM) :
                                                            dec_hold_q;

    always_comb begin
        if (!low_res) begin
            fmt_word = src;
        end else if (burst_decim) begin
            fmt_word = dec_word;
        end else begin
            fmt_word = src & `MASK_LOWRES_FULL;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || sync_restart) begin
            dec_phase_q <= `DECIM_PHASE_FIRST;
            dec_hold_q  <= '0;
        end else begin
            dec_phase_q <= dec_phase_q + 2'h1;
            if (dec_phase_q == `DECIM_PHASE_FIRST) begin
                dec_hold_q <= src & `MASK_LOWRES_DECIM;
            end
        end
    end

    // over-range: magnitude of a two's complement sample against thresh * fs / 16
    logic [DATA_W-2:0]        ovr_mag;
    logic [DATA_W-2:0]        ovr_limit;
    logic [`OVR_LATENCY-1:0]  ovr_pipe_q;

    assign ovr_mag   = adc_sample[DATA_W-1] ? ~adc_sample[DATA_W-2:0] : adc_sample[DATA_W-2:0];
    assign ovr_limit = (DATA_W-1)'({ovr_thresh_q, `OVR_SCALE_SHIFT'(0)});

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ovr_pipe_q <= '0;
        end else begin
            ovr_pipe_q <= {ovr_pipe_q[`OVR_LATENCY-2:0], ovr_mag > ovr_limit};
        end
    end

    // output stage
    logic [DATA_W-1:0] data_q;
    logic              high_resolution_flag_q;
    logic              trigger_ready_flag_q;
    logic              corr_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            data_q <= '0;
            high_resolution_flag_q <= 1'b0;
            trigger_ready_flag_q <= 1'b0;
            corr_q <= 1'b0;
        end else begin
            data_q <= fmt_word;
            high_resolution_flag_q <= (state_q == BURST_HIGH);
            trigger_ready_flag_q <= (!burst_auto && (state_q == BURST_READY)) || auto_pulse_q;
            corr_q <= mode_q[`BIT_AUTOCORR];
        end
    end

    assign output_data_bus      = data_q;
    assign output_data_clock    = dclk_q;
    assign high_resolution_flag = high_resolution_flag_q;
    assign trigger_ready_flag   = trigger_ready_flag_q;
    assign sync_marker_output   = marker_q;
    assign fast_overrange_flag  = ovr_pipe_q[`OVR_LATENCY-1];
    assign output_valid         = valid_q;
    assign autocorr_enable      = corr_q;

endmodule // adc_output_formatter_sync

`default_nettype wire

// ### dv/adc_fmt_chk.sv
// assertions on the output formatter ports, bound into the design
// assumes: burst length field stays at its reset value N=10
`timescale 1ns/10ps
`default_nettype none
module adc_fmt_chk #(parameter int DATA_W = 12) (
    input wire logic              sys_clk,
    input wire logic              rst,
    input wire logic [DATA_W-1:0] adc_sample,
    input wire logic              output_data_clock,
    input wire logic              high_resolution_flag,
    input wire logic              trigger_ready_flag,
    input wire logic              sync_marker_output,
    input wire logic              fast_overrange_flag,
    input wire logic              output_valid
);
    logic [DATA_W-1:0] mag;
    logic [15:0]       hrun_q;
    logic [15:0]       lock_q;
    logic [5:0]        inv_q;
    logic [5:0]        gap_q;
    logic              seen_q;
    // one's complement magnitude, as the over-range compare uses
    assign mag = adc_sample[DATA_W-1] ? ~adc_sample : adc_sample;
    always_ff @(posedge sys_clk) begin
        if (rst || !high_resolution_flag)
            hrun_q <= 16'h0000;
        else
            hrun_q <= hrun_q + 16'h0001;
    end
    // saturates so the lockout after enabling also reads as long
    always_ff @(posedge sys_clk) begin
        if (rst)
            lock_q <= 16'hffff;
        else if ($fell(high_resolution_flag))
            lock_q <= 16'h0001;
        else if (!high_resolution_flag && lock_q != 16'hffff)
            lock_q <= lock_q + 16'h0001;
    end
    always_ff @(posedge sys_clk) begin
        if (rst || output_valid)
            inv_q <= 6'h00;
        else
            inv_q <= inv_q + 6'h01;
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gap_q  <= 6'h00;
            seen_q <= 1'b0;
        end else if (sync_marker_output) begin
            gap_q  <= 6'h01;
            seen_q <= 1'b1;
        end else if (gap_q != 6'h3f) begin
            gap_q <= gap_q + 6'h01;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_ovr_flag_late: assert property (mag > 12'h780 |-> ##12 fast_overrange_flag)
        else $error("over-range flag missing after large sample");
    chk_ovr_zero_quiet: assert property (adc_sample == '0 |-> ##12 !fast_overrange_flag)
        else $error("over-range flag after zero sample");
    chk_high_resolution_flag_run_len: assert property ($fell(high_resolution_flag) |-> hrun_q == 16'h0400)
        else $error("high resolution run length wrong");
    chk_lockout_span: assert property ($rose(trigger_ready_flag) |-> lock_q >= 16'h2000)
        else $error("ready raised before lockout ended");
    chk_high_resolution_flag_needs_ready: assert property ($rose(high_resolution_flag)
        |-> trigger_ready_flag || $past(trigger_ready_flag))
        else $error("burst started without ready");
    chk_invalid_span: assert property ($rose(output_valid) && seen_q |-> inv_q == 6'h24)
        else $error("invalid span after sync wrong");
    chk_marker_period: assert property (sync_marker_output && seen_q && output_valid
        |-> gap_q == 6'h20)
        else $error("marker period wrong");
    chk_dclk_toggles: assert property (output_valid && $past(output_valid)
        |-> output_data_clock != $past(output_data_clock))
        else $error("output clock missed a toggle");
    cover property ($rose(high_resolution_flag));
    cover property ($rose(fast_overrange_flag));
    cover property (sync_marker_output && output_valid);
endmodule // adc_fmt_chk
bind adc_output_formatter_sync adc_fmt_chk #(.DATA_W(DATA_W)) u_chk (
    .sys_clk, .rst, .adc_sample, .output_data_clock, .high_resolution_flag,
    .trigger_ready_flag, .sync_marker_output, .fast_overrange_flag, .output_valid
);
`default_nettype wire

// ### dv/adc_rx_model.sv
// receiving logic model: takes one word on each output clock edge
// assumes: data settles within 1 ns of the output clock edge
`timescale 1ns/10ps
`default_nettype none
module adc_rx_model (
    input  wire logic        output_data_clock,
    input  wire logic [11:0] output_data_bus,
    input  wire logic        output_valid,
    output logic [11:0]      rx_word,
    output logic [31:0]      rx_kept
);
    logic [4:0] skip;
    initial begin
        rx_word = '0;
        rx_kept = '0;
        skip = '0;
    end
    // ddr: both edges carry a word
    always @(output_data_clock) begin
        #1;
        rx_word = output_data_bus;
        if (!output_valid)
            skip = 5'h12;
        else if (skip != 5'h00)
            skip = skip - 5'h01;
        else
            rx_kept = rx_kept + 1;
    end
endmodule // adc_rx_model
`default_nettype wire

// ### dv/adc_output_formatter_sync_tb_top.sv
// bench for the output formatter: patterns, burst, over-range, sync
// assumes: receiver model on the data side; link clock free of the sample clock
`timescale 1ns/10ps
`default_nettype none
module adc_output_formatter_sync_tb_top;
    import adc_fmt_pkg::*;
    logic          sys_clk = 1'b0;
    logic          link_clk = 1'b0;
    logic          rst = 1'b1;
    logic          link_rst = 1'b1;
    logic          reg_wr_en = 1'b0;
    reg_write_type reg_wr = '0;
    logic [11:0]   adc_sample = 12'h000;
    logic          burst_trigger_input = 1'b0;
    logic          sync_input = 1'b0;
    logic          ramp_on = 1'b0;
    logic          reg_busy, output_data_clock, high_resolution_flag, trigger_ready_flag;
    logic          sync_marker_output, fast_overrange_flag, output_valid, autocorr_enable;
    logic [11:0]   output_data_bus, rx_word, w0, w1;
    logic [31:0]   rx_kept;
    int            errors = 0;
    int            tests_run = 0;
    int            n, ch;
    logic [15:0]   p_up [5] = '{16'h8000, 16'hbffc, 16'h9554, 16'hbffc, 16'h9694};
    logic [15:0]   p_mid [5] = '{16'h0000, 16'h3ffc, 16'h2aa8, 16'h0000, 16'h0000};
    logic [15:0]   p_low [5] = '{16'h0000, 16'h3ffc, 16'h1554, 16'h3ffc, 16'h0000};
    logic [11:0]   p_a [5] = '{12'h000, 12'hfff, 12'haaa, 12'hfff, 12'h5a5};
    logic [11:0]   p_b [5] = '{12'h000, 12'hfff, 12'h555, 12'h000, 12'h000};
    logic [11:0]   ov_val [6] = '{12'h790, 12'h770, 12'h44c, 12'h3e8, 12'hbb4, 12'h000};
    logic [5:0]    ov_exp = 6'h15;

    adc_output_formatter_sync uut (
        .sys_clk, .rst, .link_clk, .link_rst, .reg_wr_en, .reg_wr, .reg_busy, .adc_sample,
        .burst_trigger_input, .sync_input, .output_data_bus, .output_data_clock,
        .high_resolution_flag, .trigger_ready_flag, .sync_marker_output,
        .fast_overrange_flag, .output_valid, .autocorr_enable
    );
    adc_rx_model rx (.output_data_clock, .output_data_bus, .output_valid, .rx_word, .rx_kept);

    always #2 sys_clk = ~sys_clk;
    always #3 link_clk = ~link_clk;
    always @(posedge sys_clk) begin
        if (ramp_on)
            adc_sample <= #2 adc_sample + 12'h010;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #2;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        int k;
        @(posedge link_clk);
        #2;
        reg_wr_en = 1'b1;
        reg_wr = '{addr: a, data: d};
        @(posedge link_clk);
        #2;
        reg_wr_en = 1'b0;
        k = 0;
        while (reg_busy !== 1'b0 && k < 50) begin
            @(posedge link_clk);
            k++;
        end
        if (k == 50)
            errors++;
        tick(4);
    endtask
    task automatic await(ref logic s, input logic v, input int lim, output int k);
        k = 0;
        while (s !== v && k < lim) begin
            tick(1);
            k++;
        end
    endtask
    task automatic pat(input int i);
        wr(8'h3c, p_up[i]);
        wr(8'h3d, p_mid[i]);
        wr(8'h3e, p_low[i]);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        results();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        #2 rst = 1'b0;
        @(posedge link_clk);
        #2 link_rst = 1'b0;
        tick(2);
        cmp(autocorr_enable, 0);
        wr(8'h01, 16'h8002);
        cmp(autocorr_enable, 1);
        wr(8'h01, 16'h0002);
        pat(1);
        cmp(rx_word, 12'h000);
        wr(8'h01, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            pat(i);
            tick(1);
            w0 = rx_word;
            tick(1);
            w1 = rx_word;
            // the two words alternate, so realign on the second phase
            if (w0 !== p_a[i]) begin
                tick(1);
                w0 = w1;
                w1 = rx_word;
            end
            cmp(w0, p_a[i]);
            cmp(w1, p_b[i]);
        end
        $display("pattern test done");
        pat(1);
        wr(8'h41, 16'h0005);
        wr(8'h40, 16'h0001);
        burst_trigger_input = 1'b1;
        tick(3);
        burst_trigger_input = 1'b0;
        cmp(rx_word, 12'hfe0);
        await(trigger_ready_flag, 1'b1, 9000, n);
        cmp(n > 8100 && n < 8200, 1);
        burst_trigger_input = 1'b1;
        await(high_resolution_flag, 1'b1, 12, n);
        burst_trigger_input = 1'b0;
        cmp(n < 10, 1);
        tick(4);
        cmp(rx_word, 12'hfff);
        await(high_resolution_flag, 1'b0, 1100, n);
        cmp(n + 4, 1024);
        tick(1);
        burst_trigger_input = 1'b1;
        tick(4);
        burst_trigger_input = 1'b0;
        cmp(rx_word, 12'hfe0);
        await(trigger_ready_flag, 1'b1, 9000, n);
        cmp(n + 5 >= 8192 && n + 5 <= 8194, 1);
        wr(8'h40, 16'h0000);
        cmp(rx_word, 12'hfff);
        wr(8'h40, 16'h0003);
        await(trigger_ready_flag, 1'b1, 9000, n);
        tick(1);
        cmp(trigger_ready_flag, 0);
        await(high_resolution_flag, 1'b1, 3, n);
        cmp(n < 3, 1);
        await(high_resolution_flag, 1'b0, 1100, n);
        wr(8'h40, 16'h0000);
        $display("burst test done");
        wr(8'h01, 16'h0002);
        pat(0);
        wr(8'h3c, 16'h0000);
        adc_sample = 12'h3c5;
        tick(4);
        cmp(rx_word, 12'h3c5);
        wr(8'h40, 16'h0005);
        ramp_on = 1'b1;
        tick(8);
        ch = 0;
        w0 = rx_word;
        for (int k = 0; k < 8; k++) begin
            tick(1);
            if (rx_word !== w0)
                ch++;
            w0 = rx_word;
            cmp(rx_word[0], 0);
        end
        cmp(ch, 2);
        ramp_on = 1'b0;
        wr(8'h40, 16'h0000);
        $display("decimation test done");
        for (int i = 0; i < 6; i++) begin
            if (i == 2)
                wr(8'h42, 16'h0008);
            adc_sample = ov_val[i];
            tick(16);
            cmp(fast_overrange_flag, ov_exp[i]);
        end
        $display("over-range test done");
        sync_input = 1'b1;
        tick(2);
        sync_input = 1'b0;
        await(output_valid, 1'b0, 12, n);
        await(output_valid, 1'b1, 60, n);
        cmp(n, 36);
        await(sync_marker_output, 1'b1, 40, n);
        tick(1);
        await(sync_marker_output, 1'b1, 40, n);
        cmp(n + 1, 32);
        tick(9);
        sync_input = 1'b1;
        tick(2);
        sync_input = 1'b0;
        await(output_valid, 1'b0, 12, n);
        cmp(n < 12, 1);
        await(sync_marker_output, 1'b1, 4, n);
        cmp(n < 3, 1);
        cmp(rx_kept != 0, 1);
        $display("sync test done");
        results();
    end
endmodule // adc_output_formatter_sync_tb_top
`default_nettype wire
